// File: rtl/pm_chan_cfg.sv
// configuration and status bank of a dual-channel power module
// assumes a bus engine decoding host writes into i_wr_* pulses; pins idle high
`timescale 1ns/10ps
// Functional notes
// RL1: run rising edge clears faults if enabled
// RL2: pull run low when turned off otherwise
// RL3: selects on-command during turn-off sequence
// RL4: heartbeat held low disables channel output
// RL5: external fault pin low asserts alert
// RL6: long bus timeout 255 ms option
// RL7: input current adds programmed offset
// RL8: compare ram against nvm contents
// RL9: narrow vout range; change only while stopped
// RL10: heartbeat pull low on bias lockout
// RL11: servo loops engaged or disengaged
// RL12: high or low current limit range
// RL13: three handshake bits in common status
// RL14: nvm download done status bit
// RL15: status shows alert pin driven low
// RL16: status flags heartbeat timeout event
// RL17: readable writable slave address setting
// RL18: default sync 500 kHz, 180 degrees
// RL19: strap phase makes sync input only
// RL20: frequency and phase change while idle
// RL21: channel 0 sense feeds both loops
// RL22: page selects channel 0, 1 or both
// RL23: per-channel copies, written by page
module pm_chan_cfg
   import pm_cfg_pkg::*;
(
   input wire logic i_core_clk,          // core clock
   input wire logic i_rst,               // async reset, active high
   input wire logic i_wr_stb,            // one-cycle command write strobe
   input wire logic [7:0] i_wr_cmd,      // command code
   input wire logic [15:0] i_wr_data,    // command payload
   input wire logic [7:0] i_rd_cmd,      // command code to read back
   input wire logic [1:0] i_run_n_in,    // run pins, sensed level
   input wire logic [1:0] i_fault_io_n,  // fault i/o pins, sensed level
   input wire logic i_hb_in,             // shared heartbeat line, sensed level
   input wire logic i_sync_in,           // sync line, sensed level
   input wire logic i_strap_phase,       // strap resistor sets phase
   input wire logic i_bias_uvlo,         // bias supply outside lockout window
   input wire logic [1:0] i_off_other,   // channel commanded off by other means
   input wire logic [1:0] i_on_cmd,      // one-cycle turn-on command per channel
   input wire logic [1:0] i_off_busy,    // turn-off delay and ramp still running
   input wire logic [1:0] i_switching,   // channel is switching
   input wire logic [15:0] i_iin_raw0,   // measured channel 0 input current
   input wire logic [15:0] i_iin_raw1,   // measured channel 1 input current
   input wire logic i_nvm_done,          // nvm download into ram finished
   input wire logic i_nvm_match,         // ram matches user nvm
   input wire logic [2:0] i_handshake,   // command engine busy bits
   input wire logic i_bus_tmo_evt,       // one-cycle bus timeout event from engine
   output logic [15:0] o_rd_data,        // read data for i_rd_cmd
   output logic o_fault_clear,           // one-cycle fault-clear request
   output logic [1:0] o_run_oe,          // drive run pin low
   output logic [1:0] o_on_abort,        // on-command aborts the turn-off sequence
   output logic [1:0] o_on_wait,         // on-command waits for turn-off end
   output logic [1:0] o_out_disable,     // channel output disabled by heartbeat
   output logic o_alert_oe,              // drive alert pin low
   output logic o_hb_oe,                 // drive heartbeat line low
   output logic o_sync_out,              // sync clock driven value
   output logic o_sync_oe,               // sync output enable
   output logic [15:0] o_iin0,           // channel 0 input current readback
   output logic [15:0] o_iin1,           // channel 1 input current readback
   output logic [15:0] o_iin_total,      // module input current readback
   output logic [1:0] o_narrow_range,    // narrow vout range per channel
   output logic [1:0] o_servo_on,        // digital servo engaged
   output logic [1:0] o_ilim_hi,         // high current-limit range
   output logic o_shared_fb,             // channel 0 sense feeds both
   output logic o_long_tmo,              // bus timeout extended
   output logic [6:0] o_slave_addr,      // bus slave address
   output logic [7:0] o_common_status    // common status word
);
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [1:0] run_s;
   logic [1:0] fio_s;
   logic hb_s;
   logic sync_s;
   for (genvar g = 0; g < 2; g++) begin : g_pin
      pm_sync2 u_run (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_d(i_run_n_in[g]), .o_q(run_s[g]));
      pm_sync2 u_fio (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_d(i_fault_io_n[g]),
         .o_q(fio_s[g]));
   end
   pm_sync2 u_hb (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_d(i_hb_in), .o_q(hb_s));
   pm_sync2 u_sync (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_d(i_sync_in), .o_q(sync_s));

   // ---------------------------------------------------------------
   // configuration storage
   // ---------------------------------------------------------------
   logic [7:0] page_r;
   logic [7:0] gcfg_r;
   logic [7:0] ccfg_r [2];
   logic [7:0] pmode_r [2];
   logic [7:0] pcfg_r;
   logic [15:0] iin_ofs_r [2];
   logic [6:0] addr_r;
   logic [7:0] freq_r;
   logic [7:0] phase_r;
   logic [1:0] sel;
   logic idle;

   assign idle = ~|i_switching;
   // page 0xff hits both copies, 0x00 and 0x01 one copy each; any other page value selects no channel
   assign sel = (page_r == PAGE_ALL) ? 2'b11 :                   // [RL22]
                (page_r == PAGE_CH0) ? 2'b01 :
                (page_r == PAGE_CH1) ? 2'b10 : 2'b00;

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         page_r <= PAGE_CH0;
         gcfg_r <= GCFG_RST;
         pcfg_r <= PCFG_RST;
         addr_r <= ADDR_RST;
         freq_r <= FREQ_RST;
         phase_r <= PHASE_RST;                                   // [RL18]
      end else if (i_wr_stb) begin
         unique case (i_wr_cmd)
            CMD_PAGE: page_r <= i_wr_data[7:0];                  // [RL22]
            CMD_GCFG: gcfg_r <= i_wr_data[7:0];
            CMD_PCFG: if (idle) pcfg_r <= i_wr_data[7:0];        // [RL10]
            CMD_ADDR: addr_r <= i_wr_data[6:0];                  // [RL17]
            CMD_FREQ: if (idle) freq_r <= i_wr_data[7:0];        // [RL20]
            CMD_PHASE: if (idle) phase_r <= i_wr_data[7:0];      // [RL20]
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int c = 0; c < 2; c++) begin
            ccfg_r[c] <= CCFG_RST;
            pmode_r[c] <= PMODE_RST;
            iin_ofs_r[c] <= IIN_OFS_RST;
         end
      end else if (i_wr_stb) begin
         for (int c = 0; c < 2; c++) begin
            if (sel[c]) begin                                    // [RL23]
               if (i_wr_cmd == CMD_CCFG)
                  ccfg_r[c] <= i_wr_data[7:0];
               if (i_wr_cmd == CMD_PMODE && idle)                // [RL9]
                  pmode_r[c] <= i_wr_data[7:0];
               if (i_wr_cmd == CMD_IIN_OFS)
                  iin_ofs_r[c] <= i_wr_data;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // run edges, run pull-down, heartbeat and alert
   // ---------------------------------------------------------------
   logic [1:0] run_d_r;
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         run_d_r <= 2'b11;
         o_fault_clear <= 1'b0;
      end else begin
         run_d_r <= run_s;
         o_fault_clear <= gcfg_r[GCFG_FCLR_ON_RUN] & |(run_s & ~run_d_r);   // [RL1]
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_run_oe <= 2'b00;
         o_on_abort <= 2'b00;
         o_on_wait <= 2'b00;
         o_out_disable <= 2'b00;
      end else begin
         for (int c = 0; c < 2; c++) begin
            o_run_oe[c] <= ccfg_r[c][CCFG_RUN_PULL] & i_off_other[c];       // [RL2]
            // an on-command mid turn-off either cuts the sequence short or waits
            o_on_abort[c] <= i_on_cmd[c] & i_off_busy[c] & ccfg_r[c][CCFG_ON_ABORT];  // [RL3]
            o_on_wait[c] <= i_on_cmd[c] & i_off_busy[c] & ~ccfg_r[c][CCFG_ON_ABORT];  // [RL3]
            o_out_disable[c] <= ccfg_r[c][CCFG_HB_OFF] & ~hb_s;             // [RL4]
         end
      end
   end

   logic alert_nxt;
   assign alert_nxt = (ccfg_r[0][CCFG_ALERT_FIO] & ~fio_s[0]) |
                      (ccfg_r[1][CCFG_ALERT_FIO] & ~fio_s[1]);             // [RL5]
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_alert_oe <= 1'b0;
         o_hb_oe <= 1'b0;
      end else begin
         o_alert_oe <= alert_nxt;
         o_hb_oe <= pcfg_r[PCFG_HB_UVLO] & i_bias_uvlo;                     // [RL10]
      end
   end

   // ---------------------------------------------------------------
   // heartbeat timeout: line stuck low too long sets a sticky flag
   // ---------------------------------------------------------------
   logic [15:0] hb_cnt_r;
   logic hb_tmo_r;
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         hb_cnt_r <= 16'h0000;
         hb_tmo_r <= 1'b0;
      end else begin
         if (hb_s)
            hb_cnt_r <= 16'h0000;
         else if (hb_cnt_r != 16'(HB_TMO_CYC))
            hb_cnt_r <= hb_cnt_r + 16'h0001;
         // the event wins over a clear in the same cycle
         if (!hb_s && hb_cnt_r == 16'(HB_TMO_CYC - 1))
            hb_tmo_r <= 1'b1;                                               // [RL16]
         else if (o_fault_clear)
            hb_tmo_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // sync clock: driven at 500 kHz unless the strap makes it an input
   // ---------------------------------------------------------------
   logic [9:0] sync_cnt_r;
   logic strap_r;
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         sync_cnt_r <= 10'h000;
         o_sync_out <= 1'b0;
         o_sync_oe <= 1'b0;
         strap_r <= 1'b0;
      end else begin
         strap_r <= i_strap_phase;
         o_sync_oe <= ~strap_r;                                             // [RL19]
         if (sync_cnt_r == 10'(SYNC_HALF - 1)) begin
            sync_cnt_r <= 10'h000;
            o_sync_out <= strap_r ? sync_s : ~o_sync_out;                   // [RL18]
         end else begin
            sync_cnt_r <= sync_cnt_r + 10'h001;
         end
      end
   end

   // ---------------------------------------------------------------
   // readback and mode outputs
   // ---------------------------------------------------------------
   logic [16:0] sum01;
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_iin0 <= 16'h0000;
         o_iin1 <= 16'h0000;
         o_iin_total <= 16'h0000;
      end else begin
         o_iin0 <= i_iin_raw0 + iin_ofs_r[0];                               // [RL7]
         o_iin1 <= i_iin_raw1 + iin_ofs_r[1];                               // [RL7]
         o_iin_total <= sum01[15:0];                                        // [RL7]
      end
   end
   assign sum01 = {1'b0, o_iin0} + {1'b0, o_iin1};

   logic [7:0] status_nxt;
   always_comb begin
      status_nxt = 8'h00;
      status_nxt[CST_ALERT] = o_alert_oe;                                   // [RL15]
      status_nxt[CST_HS_HI:CST_HS_LO] = i_handshake;                        // [RL13]
      status_nxt[CST_NVM_DONE] = i_nvm_done;                                // [RL14]
      status_nxt[CST_HB_TMO] = hb_tmo_r;                                    // [RL16]
   end

   logic long_tmo_r;
   logic bus_tmo_seen_r;
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_common_status <= 8'h00;
         o_narrow_range <= 2'b00;
         o_servo_on <= 2'b00;
         o_ilim_hi <= 2'b00;
         o_shared_fb <= 1'b0;
         o_long_tmo <= 1'b0;
         o_slave_addr <= ADDR_RST;
         long_tmo_r <= 1'b0;
         bus_tmo_seen_r <= 1'b0;
      end else begin
         o_common_status <= status_nxt;
         for (int c = 0; c < 2; c++) begin
            o_narrow_range[c] <= pmode_r[c][PMODE_NARROW];                  // [RL9]
            o_servo_on[c] <= pmode_r[c][PMODE_SERVO];                       // [RL11]
            o_ilim_hi[c] <= pmode_r[c][PMODE_ILIM_HI];                      // [RL12]
         end
         o_shared_fb <= pcfg_r[PCFG_SHARED_FB];                             // [RL21]
         long_tmo_r <= gcfg_r[GCFG_LONG_TMO];
         o_long_tmo <= long_tmo_r;                                          // [RL6]
         o_slave_addr <= addr_r;                                            // [RL17]
         bus_tmo_seen_r <= i_bus_tmo_evt | (bus_tmo_seen_r & ~o_fault_clear);
      end
   end

   logic [15:0] rd_nxt;
   always_comb begin
      rd_nxt = 16'h0000;
      unique case (i_rd_cmd)
         CMD_PAGE: rd_nxt = {8'h00, page_r};
         CMD_GCFG: rd_nxt = {8'h00, gcfg_r};
         CMD_CCFG: rd_nxt = {8'h00, ccfg_r[page_r[0]]};
         CMD_PMODE: rd_nxt = {8'h00, pmode_r[page_r[0]]};
         CMD_PCFG: rd_nxt = {8'h00, pcfg_r};
         CMD_IIN_OFS: rd_nxt = iin_ofs_r[page_r[0]];
         CMD_ADDR: rd_nxt = {9'h000, addr_r};                               // [RL17]
         CMD_FREQ: rd_nxt = {8'h00, freq_r};
         CMD_PHASE: rd_nxt = {8'h00, phase_r};
         CMD_CMP: rd_nxt = {14'h0000, bus_tmo_seen_r, i_nvm_match};         // [RL8]
         CMD_STAT: rd_nxt = {8'h00, o_common_status};
         default: rd_nxt = 16'h0000;
      endcase
   end
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst)
         o_rd_data <= 16'h0000;
      else
         o_rd_data <= rd_nxt;
   end
endmodule // pm_chan_cfg

// File: rtl/pm_cfg_pkg.sv
// package: constants for the dual-channel power module configuration and status block
// assumes a 250 MHz core clock; the bus engine presents decoded command writes
package pm_cfg_pkg;
   // global config word fields
   localparam int GCFG_FCLR_ON_RUN = 0;
   localparam int GCFG_LONG_TMO = 3;
   localparam logic [7:0] GCFG_RST = 8'h00;
   // channel config word fields
   localparam int CCFG_ALERT_FIO = 1;
   localparam int CCFG_HB_OFF = 2;
   localparam int CCFG_ON_ABORT = 3;
   localparam int CCFG_RUN_PULL = 4;
   localparam logic [7:0] CCFG_RST = 8'h00;
   // pwm mode word fields
   localparam int PMODE_NARROW = 1;
   localparam int PMODE_SERVO = 6;
   localparam int PMODE_ILIM_HI = 7;
   localparam logic [7:0] PMODE_RST = 8'h00;
   // pwm config word fields
   localparam int PCFG_HB_UVLO = 4;
   localparam int PCFG_SHARED_FB = 7;
   localparam logic [7:0] PCFG_RST = 8'h00;
   // common status word fields
   localparam int CST_HB_TMO = 1;
   localparam int CST_NVM_DONE = 3;
   localparam int CST_HS_LO = 4;
   localparam int CST_HS_HI = 6;
   localparam int CST_ALERT = 7;
   // command codes seen on the internal write port
   localparam logic [7:0] CMD_PAGE = 8'h00;
   localparam logic [7:0] CMD_GCFG = 8'h01;
   localparam logic [7:0] CMD_CCFG = 8'h02;
   localparam logic [7:0] CMD_PMODE = 8'h03;
   localparam logic [7:0] CMD_PCFG = 8'h04;
   localparam logic [7:0] CMD_IIN_OFS = 8'h05;
   localparam logic [7:0] CMD_ADDR = 8'h06;
   localparam logic [7:0] CMD_FREQ = 8'h07;
   localparam logic [7:0] CMD_PHASE = 8'h08;
   localparam logic [7:0] CMD_CMP = 8'h09;
   localparam logic [7:0] CMD_STAT = 8'h0A;
   localparam logic [7:0] PAGE_CH0 = 8'h00;
   localparam logic [7:0] PAGE_CH1 = 8'h01;
   localparam logic [7:0] PAGE_ALL = 8'hFF;
   localparam logic [6:0] ADDR_RST = 7'h4F;      // arbitrary default slave address
   localparam logic [15:0] IIN_OFS_RST = 16'h0000;
   // sync clock: 250 MHz / 500 kHz = 500 cycles a period
   localparam int CLK_MHZ = 250;
   localparam int SYNC_KHZ = 500;
   localparam int SYNC_HALF = (CLK_MHZ * 1000) / SYNC_KHZ / 2;
   localparam logic [7:0] FREQ_RST = 8'h00;
   localparam logic [7:0] PHASE_RST = 8'h80;     // 180 degrees, 1 lsb = 360/256
   // bus and heartbeat timeout figures
   localparam int TMO_LONG_MS = 255;
   localparam int HB_TMO_US = 100;
   localparam int HB_TMO_CYC = HB_TMO_US * CLK_MHZ;
endpackage : pm_cfg_pkg

// File: rtl/pm_sync2.sv
// two-flop synchroniser for pins coming from outside the core clock domain
// assumes the input is a slow level
`timescale 1ns/10ps
module pm_sync2 (
   input wire logic i_core_clk, // core clock
   input wire logic i_rst,      // async reset, active high
   input wire logic i_d,        // asynchronous level
   output logic o_q             // synchronised level
);
   logic meta_r;
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_r <= 1'b1;
         o_q <= 1'b1;
      end else begin
         meta_r <= i_d;
         o_q <= meta_r;
      end
   end
endmodule // pm_sync2

// File: verif/pm_cfg_props.sv
// checker: port timing of the config and status bank
// assumes a bind onto pm_chan_cfg; one core clock domain, async reset
`timescale 1ns/10ps
module pm_cfg_props
   import pm_cfg_pkg::*;
(
   input wire logic i_core_clk,            // core clock
   input wire logic i_rst,                 // reset
   input wire logic i_wr_stb,              // write strobe
   input wire logic [7:0] i_wr_cmd,        // command code
   input wire logic [15:0] i_wr_data,      // payload
   input wire logic i_strap_phase,         // strap sets phase
   input wire logic [1:0] i_on_cmd,        // turn-on pulses
   input wire logic [2:0] i_handshake,     // busy bits
   input wire logic i_nvm_done,            // nvm download done
   input wire logic o_fault_clear,         // fault clear pulse
   input wire logic [1:0] o_on_abort,      // abort response
   input wire logic [1:0] o_on_wait,       // wait response
   input wire logic o_alert_oe,            // alert drive
   input wire logic o_sync_out,            // sync value
   input wire logic o_sync_oe,             // sync enable
   input wire logic [15:0] o_iin0,         // channel 0 current
   input wire logic [15:0] o_iin1,         // channel 1 current
   input wire logic [15:0] o_iin_total,    // module current
   input wire logic o_long_tmo,            // long bus timeout
   input wire logic [7:0] o_common_status  // status word
);
   // ----------------------------------------
   // sync half-period counter
   // ----------------------------------------
   logic prev_r;
   logic seen_r;
   logic [15:0] cnt_r;
   // the first edge after enable has an unknown distance, so it only arms the check
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         prev_r <= 1'b0;
         seen_r <= 1'b0;
         cnt_r <= 16'h0000;
      end else begin
         prev_r <= o_sync_out;
         cnt_r <= (o_sync_out != prev_r) ? 16'h0000 : cnt_r + 16'h0001;
         seen_r <= o_sync_oe && (seen_r || (o_sync_out != prev_r));
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);
   a_fclr_pulse: assert property (o_fault_clear |=> !o_fault_clear)
      else $error("fault clear longer than one cycle");
   a_iin_total: assert property (o_iin_total == 16'($past(o_iin0) + $past(o_iin1)))
      else $error("total current is not the channel sum");
   a_hs_status: assert property (o_common_status[6:4] == $past(i_handshake))
      else $error("handshake bits do not follow engine");
   a_nvm_status: assert property (o_common_status[3] == $past(i_nvm_done))
      else $error("nvm done bit does not follow download");
   a_alert_status: assert property ($rose(o_alert_oe) |-> ##[0:1] o_common_status[7])
      else $error("alert status bit missing");
   a_sync_off: assert property (i_strap_phase [*2] |=> !o_sync_oe)
      else $error("sync driven while strap sets phase");
   a_sync_drive: assert property (!i_strap_phase [*2] |=> o_sync_oe)
      else $error("sync not driven by default");
   a_sync_half: assert property ((o_sync_out != prev_r) && seen_r && o_sync_oe
      |-> cnt_r == 16'(SYNC_HALF - 1))
      else $error("sync half period wrong");
   a_long_tmo: assert property ($rose(o_long_tmo) |->
      $past(i_wr_stb, 3) && $past(i_wr_cmd, 3) == CMD_GCFG && $past(i_wr_data[3], 3))
      else $error("long timeout set without a write");
   a_on_resp: assert property (|(o_on_abort | o_on_wait) |->
      (((o_on_abort | o_on_wait) & ~$past(i_on_cmd)) == 2'b00) &&
      ((o_on_abort & o_on_wait) == 2'b00))
      else $error("turn-on response without command");
endmodule // pm_cfg_props

// File: verif/pm_host_model.sv
// host model: issues command writes and read selects like the bus engine
// assumes tasks are called from one bench process at a time
`timescale 1ns/10ps
module pm_host_model
   import pm_cfg_pkg::*;
(
   input wire logic i_core_clk,        // core clock
   input wire logic [15:0] i_rd_data,  // read data
   output logic o_wr_stb,              // write strobe
   output logic [7:0] o_wr_cmd,        // command code
   output logic [15:0] o_wr_data,      // payload
   output logic [7:0] o_rd_cmd         // read select
);
   initial begin
      o_wr_stb = 1'b0;
      o_wr_cmd = 8'h00;
      o_wr_data = 16'h0000;
      o_rd_cmd = 8'h00;
   end
   // released lines show the inverse so stale values stand out
   task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
      @(posedge i_core_clk);
      #1;
      o_wr_stb = 1'b1;
      o_wr_cmd = cmd;
      o_wr_data = data;
      @(posedge i_core_clk);
      #1;
      o_wr_stb = 1'b0;
      o_wr_cmd = ~cmd;
      o_wr_data = ~data;
   endtask
   task automatic page(input logic [7:0] sel);
      wr(CMD_PAGE, {8'h00, sel});
   endtask
   task automatic rd(input logic [7:0] cmd, output logic [15:0] data);
      @(posedge i_core_clk);
      #1;
      o_rd_cmd = cmd;
      @(posedge i_core_clk);
      #1;
      data = i_rd_data;
   endtask
endmodule // pm_host_model

// File: verif/pm_chan_cfg_test.sv
// testbench: command sequences with expected port values for pm_chan_cfg
// assumes pm_host_model drives the write port; pins idle high with pull-ups
`timescale 1ns/10ps
module pm_chan_cfg_test
   import pm_cfg_pkg::*;
;
   logic i_core_clk = 1'b0, i_rst = 1'b1, i_strap_phase = 1'b0, i_bias_uvlo = 1'b0;
   logic i_nvm_done = 1'b0, i_nvm_match = 1'b0, i_bus_tmo_evt = 1'b0, hb_drv = 1'b1;
   logic ext_sync = 1'b0, i_wr_stb, o_fault_clear, o_alert_oe, o_hb_oe, o_sync_out;
   logic o_sync_oe, o_shared_fb, o_long_tmo;
   logic [1:0] i_fault_io_n = 2'b11, i_off_other = 2'b00, i_on_cmd = 2'b00;
   logic [1:0] i_off_busy = 2'b00, i_switching = 2'b00, run_drv = 2'b11;
   logic [1:0] o_run_oe, o_on_abort, o_on_wait, o_out_disable, o_narrow_range;
   logic [1:0] o_servo_on, o_ilim_hi;
   logic [2:0] i_handshake = 3'b000;
   logic [7:0] i_wr_cmd, i_rd_cmd, o_common_status;
   logic [15:0] i_wr_data, o_rd_data, o_iin0, o_iin1, o_iin_total;
   logic [15:0] i_iin_raw0 = 16'h0100, i_iin_raw1 = 16'h0200;
   logic [6:0] o_slave_addr;
   int failures = 0, n_checks = 0;
   // open-drain and shared lines: wire level from every party's enable
   wire i_hb_in = hb_drv && !o_hb_oe;
   wire [1:0] i_run_n_in = run_drv & ~o_run_oe;
   wire i_sync_in = o_sync_oe ? o_sync_out : ext_sync;
   initial forever #2 i_core_clk = ~i_core_clk;
   initial begin
      #3;
      forever #16 ext_sync = ~ext_sync;
   end
   pm_chan_cfg u_pm_chan_cfg (.*);
   pm_host_model u_pm_host_model (.i_core_clk, .i_rd_data(o_rd_data), .o_wr_stb(i_wr_stb),
      .o_wr_cmd(i_wr_cmd), .o_wr_data(i_wr_data), .o_rd_cmd(i_rd_cmd));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
      u_pm_host_model.wr(cmd, data);
   endtask
   task automatic pg(input logic [7:0] sel);
      u_pm_host_model.page(sel);
   endtask
   task automatic rchk(input string nm, input logic [7:0] cmd, input logic [15:0] exp);
      logic [15:0] v;
      u_pm_host_model.rd(cmd, v);
      chk(nm, exp, v);
   endtask
   task automatic conclude;
      if (failures == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      tick(8);
      i_rst = 1'b0;
      chk("slave_addr", {9'h000, ADDR_RST}, {9'h000, o_slave_addr});
      rchk("phase_rst", CMD_PHASE, {8'h00, PHASE_RST});
      wr(CMD_ADDR, 16'h0022);
      tick(2);
      chk("slave_addr", 16'h0022, {9'h000, o_slave_addr});
      rchk("addr_rd", CMD_ADDR, 16'h0022);
      pg(PAGE_CH0);
      wr(CMD_CCFG, 16'h0004);
      pg(PAGE_CH1);
      wr(CMD_CCFG, 16'h0010);
      rchk("ccfg1", CMD_CCFG, 16'h0010);
      pg(8'h05);
      wr(CMD_CCFG, 16'h00FF);
      pg(PAGE_CH0);
      rchk("ccfg0", CMD_CCFG, 16'h0004);
      hb_drv = 1'b0;
      tick(4);
      chk("out_disable", 16'h0001, {14'h0000, o_out_disable});
      tick(HB_TMO_CYC + 8);
      chk("hb_tmo_set", 16'h0001, {15'h0000, o_common_status[1]});
      hb_drv = 1'b1;
      i_off_other = 2'b11;
      tick(3);
      chk("run_oe", 16'h0002, {14'h0000, o_run_oe});
      i_off_other = 2'b00;
      pg(PAGE_ALL);
      wr(CMD_CCFG, 16'h000A);
      pg(PAGE_CH1);
      rchk("ccfg_all", CMD_CCFG, 16'h000A);
      i_fault_io_n = 2'b01;
      tick(4);
      chk("alert_oe", 16'h0001, {15'h0000, o_alert_oe});
      chk("alert_stat", 16'h0001, {15'h0000, o_common_status[7]});
      i_fault_io_n = 2'b11;
      wr(CMD_CCFG, 16'h0002);
      i_off_busy = 2'b11;
      i_on_cmd = 2'b11;
      tick(1);
      i_on_cmd = 2'b00;
      chk("on_resp", 16'h0006, {12'h000, o_on_abort, o_on_wait});
      i_off_busy = 2'b00;
      wr(CMD_GCFG, 16'h0009);
      tick(2);
      chk("long_tmo", 16'h0001, {15'h0000, o_long_tmo});
      run_drv = 2'b10;
      tick(4);
      run_drv = 2'b11;
      for (int i = 0; i < 8 && o_fault_clear !== 1'b1; i++) tick(1);
      chk("fault_clear", 16'h0001, {15'h0000, o_fault_clear});
      if (o_fault_clear !== 1'b1) conclude();
      tick(2);
      chk("hb_tmo_clr", 16'h0000, {15'h0000, o_common_status[1]});
      pg(PAGE_CH0);
      i_switching = 2'b01;
      wr(CMD_PMODE, 16'h00C2);
      wr(CMD_FREQ, 16'h0033);
      tick(2);
      chk("pmode_gated", 16'h0000, {10'h000, o_narrow_range, o_servo_on, o_ilim_hi});
      rchk("freq_gated", CMD_FREQ, {8'h00, FREQ_RST});
      i_switching = 2'b00;
      wr(CMD_PMODE, 16'h00C2);
      wr(CMD_FREQ, 16'h0033);
      tick(2);
      chk("pmode", 16'h0015, {10'h000, o_narrow_range, o_servo_on, o_ilim_hi});
      rchk("freq", CMD_FREQ, 16'h0033);
      wr(CMD_PHASE, 16'h0040);
      rchk("phase", CMD_PHASE, 16'h0040);
      wr(CMD_PCFG, 16'h0090);
      i_bias_uvlo = 1'b1;
      tick(3);
      chk("hb_oe_fb", 16'h0003, {14'h0000, o_hb_oe, o_shared_fb});
      i_bias_uvlo = 1'b0;
      pg(PAGE_ALL);
      wr(CMD_IIN_OFS, 16'h0010);
      tick(3);
      chk("iin0", 16'h0110, o_iin0);
      chk("iin1", 16'h0210, o_iin1);
      chk("iin_total", 16'h0320, o_iin_total);
      i_nvm_match = 1'b1;
      i_bus_tmo_evt = 1'b1;
      tick(1);
      i_bus_tmo_evt = 1'b0;
      rchk("compare", CMD_CMP, 16'h0003);
      i_handshake = 3'b101;
      i_nvm_done = 1'b1;
      tick(2);
      chk("status", 16'h0058, {8'h00, o_common_status & 8'h78});
      i_strap_phase = 1'b1;
      tick(2);
      chk("sync_oe_off", 16'h0000, {15'h0000, o_sync_oe});
      i_strap_phase = 1'b0;
      tick(600);
      chk("sync_oe_on", 16'h0001, {15'h0000, o_sync_oe});
      conclude();
   end
endmodule // pm_chan_cfg_test
bind pm_chan_cfg pm_cfg_props u_pm_cfg_props (.i_core_clk, .i_rst, .i_wr_stb, .i_wr_cmd,
   .i_wr_data, .i_strap_phase, .i_on_cmd, .i_handshake, .i_nvm_done, .o_fault_clear,
   .o_on_abort, .o_on_wait, .o_alert_oe, .o_sync_out, .o_sync_oe, .o_iin0, .o_iin1,
   .o_iin_total, .o_long_tmo, .o_common_status);
